// ==== inc/cdbt_pkg.sv ====
// shared constants and types for the debug breakpoint and trace block
package cdbt_pkg;
    // ------------------------------------------------------------
    // breakpoint register file
    // ------------------------------------------------------------
    localparam int NUM_BKPT = 9;
    localparam int IDX_W = 4;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_ADDR_MASK = 4'h1;
    localparam logic [3:0] IDX_DATA = 4'h2;
    localparam logic [3:0] IDX_DATA_MASK = 4'h3;
    localparam logic [3:0] IDX_PC_FIRST = 4'h4;
    localparam logic [3:0] IDX_PC_MASK = 4'h8;
    localparam int NUM_PC = 4;
    localparam logic [31:0] BKPT_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // serial channel and trace
    // ------------------------------------------------------------
    localparam logic [5:0] FRAME_LAST = 6'h24;
    localparam logic [3:0] STATUS_HALTED = 4'hF;
    localparam logic [3:0] STATUS_RUN_SUBST = 4'hE;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // selection bits: [2] address, [1] data, [0] program counter
    typedef struct packed {
        logic enable;
        logic two_level;
        logic irq_action;
        logic [2:0] first_sel;
        logic [2:0] second_sel;
    } cdbt_trig_cfg_type;
    typedef struct packed {
        logic wr;
        logic [3:0] idx;
        logic [31:0] data;
    } cdbt_cmd_type;
    typedef struct packed {
        logic addr_valid;
        logic [31:0] addr;
        logic data_valid;
        logic [31:0] data;
        logic pc_valid;
        logic [31:0] pc;
    } cdbt_core_obs_type;
    typedef enum {TRG_IDLE, TRG_ARMED} cdbt_trig_state_type;
endpackage : cdbt_pkg

// ==== tb/cdbt_tool.sv ====
// serial debug tool model for the three-wire debug channel
`timescale 1ns/1ps
module cdbt_tool
    import cdbt_pkg::*;
(
    output logic debug_serial_clock,
    output logic debug_serial_in,
    input wire logic debug_serial_out
);
    initial begin
        debug_serial_clock = 1'b0;
        debug_serial_in = 1'b1;
    end
    // ------------------------------------------------------------
    // link clocking
    // ------------------------------------------------------------
    // loose clocks only around reset, the link resyncs it through flops
    task automatic pulse(input int n);
        repeat (n) begin
            #7.5 debug_serial_clock = 1'b1;
            #7.5 debug_serial_clock = 1'b0;
        end
    endtask : pulse
    // one 37-bit command, msb first; r gets the answer to the previous one
    task automatic frame(input cdbt_cmd_type c, output logic [31:0] r);
        r = 32'h0;
        for (int j = 0; j < 37; j++) begin
            debug_serial_in = c[36-j];
            if (j >= 1 && j <= 32) r[32-j] = debug_serial_out;
            #7.5 debug_serial_clock = 1'b1;
            #7.5 debug_serial_clock = 1'b0;
        end
        // released line must not keep looking like the last bit
        debug_serial_in = ~debug_serial_in;
    endtask : frame
endmodule : cdbt_tool

// ==== tb/tb.sv ====
// self-checking bench for the debug breakpoint and trace block
`timescale 1ns/1ps
module tb
    import cdbt_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic cpu_access = 1'b0, cpu_write = 1'b0, cpu_supervisor = 1'b0;
    logic [3:0] cpu_index = 4'h0, core_status = 4'h0, core_trace_data = 4'h0;
    logic [31:0] cpu_wdata = 32'h0, cpu_rdata, seed = 32'h5517, r, d;
    logic core_halted = 1'b0, debug_irq_active = 1'b0;
    logic irq_pending = 1'b0, irq_critical = 1'b0, cpu_ack, halt_request;
    logic debug_irq_request, irq_take, trace_clock_out, all_status_high, tc;
    logic debug_serial_clock, debug_serial_in, debug_serial_out;
    logic [3:0] processor_status_out, debug_data_out, ps;
    cdbt_core_obs_type core_obs = '0;
    cdbt_trig_cfg_type trig_cfg = '0;
    logic [31:0] mdl [9];
    logic [32:0] q_rd [$];
    logic [1:0] q_ev [$];
    logic [32:0] e;
    int bad_count = 0, n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    cdbt_debug i_cdbt_debug (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .debug_serial_clock(debug_serial_clock), .debug_serial_in(debug_serial_in),
        .debug_serial_out(debug_serial_out), .cpu_access(cpu_access), .cpu_write(cpu_write),
        .cpu_supervisor(cpu_supervisor), .cpu_index(cpu_index), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .core_obs(core_obs), .trig_cfg(trig_cfg),
        .core_halted(core_halted), .core_status(core_status),
        .core_trace_data(core_trace_data), .debug_irq_active(debug_irq_active),
        .irq_pending(irq_pending), .irq_critical(irq_critical),
        .halt_request(halt_request), .debug_irq_request(debug_irq_request),
        .irq_take(irq_take), .processor_status_out(processor_status_out),
        .debug_data_out(debug_data_out), .trace_clock_out(trace_clock_out),
        .all_status_high(all_status_high));
    cdbt_tool i_cdbt_tool (.debug_serial_clock(debug_serial_clock),
        .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // leaves cpu_access high so that calls run back to back
    task automatic cpu_req(input logic w, input logic sup, input logic [3:0] i,
                           input logic [31:0] dt);
        q_rd.push_back({~w, (sup && i < 4'h9) ? mdl[i] : 32'h0});
        if (w && sup && i < 4'h9) mdl[i] = dt;
        @(posedge sys_clk);
        cpu_access <= 1'b1;
        cpu_write <= w;
        cpu_supervisor <= sup;
        cpu_index <= i;
        cpu_wdata <= dt;
    endtask : cpu_req
    task automatic cpu_end();
        @(posedge sys_clk);
        cpu_access <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : cpu_end
    task automatic cfg(input cdbt_trig_cfg_type c);
        @(posedge sys_clk);
        trig_cfg <= '0;
        @(posedge sys_clk);
        trig_cfg <= c;
        @(posedge sys_clk);
    endtask : cfg
    task automatic obs(input cdbt_core_obs_type o, input logic [1:0] ev);
        if (ev != 2'h0) q_ev.push_back(ev);
        @(posedge sys_clk);
        core_obs <= o;
        @(posedge sys_clk);
        core_obs <= '0;
        repeat (3) @(posedge sys_clk);
    endtask : obs
    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (cpu_ack === 1'b1) begin
            if (q_rd.size() == 0) check("cpu_ack", 32'h0, 32'h1);
            else begin
                e = q_rd.pop_front();
                if (e[32]) check("cpu_rdata", e[31:0], cpu_rdata);
            end
        end
        if (halt_request === 1'b1 || debug_irq_request === 1'b1) begin
            if (q_ev.size() == 0) check("trigger", 32'h0, 32'h1);
            else check("trigger", {30'h0, q_ev.pop_front()},
                       {30'h0, debug_irq_request, halt_request});
        end
    end
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        foreach (mdl[i]) mdl[i] = BKPT_RESET;
        i_cdbt_tool.pulse(4);
        @(posedge sys_clk);
        reset <= 1'b0;
        // a third edge would already shift in as frame bit zero
        i_cdbt_tool.pulse(2);
        for (int i = 0; i < 9; i++) cpu_req(1'b0, 1'b1, i[3:0], 32'h0);
        for (int i = 0; i < 9; i++) cpu_req(1'b1, 1'b1, i[3:0], xs());
        for (int i = 0; i < 9; i++) cpu_req(1'b0, 1'b1, i[3:0], 32'h0);
        cpu_req(1'b1, 1'b0, 4'h2, 32'h0);
        cpu_req(1'b0, 1'b1, 4'h2, 32'h0);
        cpu_req(1'b0, 1'b0, 4'h2, 32'h0);
        cpu_req(1'b1, 1'b1, 4'h9, 32'h0);
        cpu_req(1'b0, 1'b1, 4'hF, 32'h0);
        cpu_end();
        $display("cpu register test done");
        d = xs();
        i_cdbt_tool.frame({1'b1, 4'h5, d}, r);
        mdl[5] = d;
        repeat (8) @(posedge sys_clk);
        cpu_req(1'b0, 1'b1, 4'h5, 32'h0);
        cpu_end();
        i_cdbt_tool.frame({1'b0, 4'h0, 32'h0}, r);
        repeat (8) @(posedge sys_clk);
        i_cdbt_tool.frame({1'b0, 4'h9, 32'h0}, r);
        check("serial read", mdl[0], r);
        repeat (8) @(posedge sys_clk);
        i_cdbt_tool.frame({1'b0, 4'h0, 32'h0}, r);
        check("serial read", 32'h0, r);
        $display("serial channel test done");
        cpu_req(1'b1, 1'b1, 4'h1, 32'h0000_00FF);
        cpu_req(1'b1, 1'b1, 4'h3, 32'h0);
        cpu_req(1'b1, 1'b1, 4'h8, 32'h0);
        cpu_end();
        cfg(9'b1_0_0_100_000);
        obs({1'b1, mdl[0] ^ 32'h5A, 1'b0, 32'h0, 1'b0, 32'h0}, 2'h1);
        obs({1'b1, mdl[0] ^ 32'h100, 1'b0, 32'h0, 1'b0, 32'h0}, 2'h0);
        // an all-ones mask lets any address through
        cpu_req(1'b1, 1'b1, 4'h1, 32'hFFFF_FFFF);
        cpu_end();
        obs({1'b1, xs(), 1'b0, 32'h0, 1'b0, 32'h0}, 2'h1);
        cfg(9'b1_0_1_011_000);
        obs({1'b0, 32'h0, 1'b1, mdl[2], 1'b1, mdl[7]}, 2'h2);
        obs({1'b0, 32'h0, 1'b1, mdl[2], 1'b0, 32'h0}, 2'h0);
        cfg(9'b1_1_0_100_001);
        obs({1'b0, 32'h0, 1'b0, 32'h0, 1'b1, mdl[4]}, 2'h0);
        obs({1'b1, mdl[0], 1'b0, 32'h0, 1'b0, 32'h0}, 2'h0);
        // dropping enable for a cycle must forget the arm
        cfg(9'b1_1_0_100_001);
        obs({1'b0, 32'h0, 1'b0, 32'h0, 1'b1, mdl[4]}, 2'h0);
        obs({1'b1, mdl[0], 1'b0, 32'h0, 1'b0, 32'h0}, 2'h0);
        obs({1'b0, 32'h0, 1'b0, 32'h0, 1'b1, mdl[4]}, 2'h1);
        cfg(9'h0);
        $display("trigger test done");
        for (int i = 0; i < 16; i++) begin
            d = xs();
            @(posedge sys_clk);
            {irq_pending, debug_irq_active, irq_critical} <= i[2:0];
            core_halted <= d[0];
            core_status <= (i == 3) ? 4'hF : d[4:1];
            core_trace_data <= d[8:5];
            @(posedge sys_clk);
            @(negedge sys_clk);
            tc = trace_clock_out;
            ps = d[0] ? STATUS_HALTED : ((i == 3 || d[4:1] == 4'hF) ? 4'hE : d[4:1]);
            check("irq_take", {31'h0, i[2] && (!i[1] || i[0])}, {31'h0, irq_take});
            check("status", {28'h0, ps}, {28'h0, processor_status_out});
            check("all_status", {31'h0, &ps}, {31'h0, all_status_high});
            check("trace data", {28'h0, d[8:5]}, {28'h0, debug_data_out});
            @(negedge sys_clk);
            check("trace clock", {31'h0, ~tc}, {31'h0, trace_clock_out});
        end
        $display("status and interrupt test done");
        // inputs move while the enable is low; outputs must hold
        @(posedge sys_clk);
        clk_en <= 1'b0;
        core_status <= ~ps;
        core_trace_data <= ~d[8:5];
        irq_pending <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check("frozen status", {28'h0, ps}, {28'h0, processor_status_out});
        check("frozen trace clock", {31'h0, tc}, {31'h0, trace_clock_out});
        check("frozen trace data", {28'h0, d[8:5]}, {28'h0, debug_data_out});
        check("frozen irq_take", 32'h1, {31'h0, irq_take});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        $display("clock enable test done");
        check("open notes", 32'h0, q_rd.size() + q_ev.size());
        give_verdict();
    end
endmodule : tb

// ==== verilog/cdbt_debug.sv ====
// debug breakpoint, trigger, trace and serial register access logic
//
// Contract
// RULE_01: all_status_high is the AND of the four processor_status_out bits.
// RULE_02: status shows all ones while halted, never otherwise.
// RULE_03: nine 32-bit breakpoint registers: address, data, four pc, three masks.
// RULE_04: registers read and written by serial channel and supervisor cpu.
// RULE_05: triggers combine address, data, pc matches; one or two levels.
// RULE_06: a fired trigger halts the core or raises a debug interrupt.
// RULE_07: critical interrupts are still taken during debug interrupt service.
// RULE_08: status and debug data nibbles at cpu rate with a trace clock.
// RULE_09: mask bits set to one make that bit position a don't-care.
`timescale 1ns/1ps
module cdbt_debug
    import cdbt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic debug_serial_clock,
    input wire logic debug_serial_in,
    output logic debug_serial_out,
    input wire logic cpu_access,
    input wire logic cpu_write,
    input wire logic cpu_supervisor,
    input wire logic [IDX_W-1:0] cpu_index,
    input wire logic [31:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic cpu_ack,
    input wire cdbt_core_obs_type core_obs,
    input wire cdbt_trig_cfg_type trig_cfg,
    input wire logic core_halted,
    input wire logic [3:0] core_status,
    input wire logic [3:0] core_trace_data,
    input wire logic debug_irq_active,
    input wire logic irq_pending,
    input wire logic irq_critical,
    output logic halt_request,
    output logic debug_irq_request,
    output logic irq_take,
    output logic [3:0] processor_status_out,
    output logic [3:0] debug_data_out,
    output logic trace_clock_out,
    output logic all_status_high
);
    // ------------------------------------------------------------
    // link domain: serial shifter
    // ------------------------------------------------------------
    // the serial clock stops between frames; a frame is always 37 edges
    logic link_rst_meta, link_rst;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [35:0] shift_in, next_shift_in;
    logic [31:0] shift_out, next_shift_out;
    logic next_serial_out;
    cdbt_cmd_type link_cmd, next_link_cmd;
    logic req_tgl, next_req_tgl;
    logic [31:0] serial_rdata;

    always_ff @(posedge debug_serial_clock) begin
        link_rst_meta <= reset;
        link_rst <= link_rst_meta;
    end

    always_comb begin
        next_bit_cnt = bit_cnt + 6'h01;
        next_shift_in = {shift_in[34:0], debug_serial_in};
        next_shift_out = {shift_out[30:0], 1'b0};
        next_serial_out = shift_out[31];
        next_link_cmd = link_cmd;
        next_req_tgl = req_tgl;
        if (bit_cnt == 6'h00) begin
            // read data settled in the sys domain long before this frame began
            next_shift_out = {serial_rdata[30:0], 1'b0};
            next_serial_out = serial_rdata[31];
        end
        if (bit_cnt == FRAME_LAST) begin
            next_bit_cnt = 6'h00;
            next_link_cmd = {shift_in, debug_serial_in}; // RULE_04
            next_req_tgl = ~req_tgl;
        end
    end

    always_ff @(posedge debug_serial_clock) begin
        if (link_rst) begin
            bit_cnt <= 6'h00;
            shift_in <= '0;
            shift_out <= '0;
            debug_serial_out <= 1'b0;
            link_cmd <= '0;
            req_tgl <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            debug_serial_out <= next_serial_out;
            link_cmd <= next_link_cmd;
            req_tgl <= next_req_tgl;
        end
    end

    // ------------------------------------------------------------
    // sys domain: register file and access arbitration
    // ------------------------------------------------------------
    logic req_meta, req_sync, req_seen, next_req_seen;
    logic [31:0] bkpt [NUM_BKPT];
    logic [31:0] next_bkpt [NUM_BKPT];
    logic [31:0] next_cpu_rdata, next_serial_rdata;
    logic next_cpu_ack;
    logic serial_go, cpu_ok;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else if (clk_en) begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
        end
    end

    // cpu wins a collision; the serial request waits until cpu_access drops
    assign cpu_ok = cpu_access && cpu_supervisor;
    assign serial_go = (req_sync != req_seen) && !cpu_access;

    always_comb begin
        next_bkpt = bkpt;
        next_cpu_rdata = 32'h0000_0000;
        next_cpu_ack = cpu_access;
        next_serial_rdata = serial_rdata;
        next_req_seen = req_seen;
        if (cpu_ok && (cpu_index < IDX_W'(NUM_BKPT))) begin
            if (cpu_write) begin
                next_bkpt[cpu_index] = cpu_wdata; // RULE_04
            end else begin
                next_cpu_rdata = bkpt[cpu_index]; // RULE_04
            end
        end
        if (serial_go) begin
            next_req_seen = req_sync;
            if (link_cmd.idx < IDX_W'(NUM_BKPT)) begin
                if (link_cmd.wr) begin
                    next_bkpt[link_cmd.idx] = link_cmd.data; // RULE_04
                end else begin
                    next_serial_rdata = bkpt[link_cmd.idx]; // RULE_04
                end
            end else begin
                next_serial_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_BKPT; i++) begin
                bkpt[i] <= BKPT_RESET; // RULE_03
            end
            cpu_rdata <= 32'h0000_0000;
            cpu_ack <= 1'b0;
            serial_rdata <= 32'h0000_0000;
            req_seen <= 1'b0;
        end else if (clk_en) begin
            bkpt <= next_bkpt;
            cpu_rdata <= next_cpu_rdata;
            cpu_ack <= next_cpu_ack;
            serial_rdata <= next_serial_rdata;
            req_seen <= next_req_seen;
        end
    end

    // ------------------------------------------------------------
    // comparators and trigger sequencer
    // ------------------------------------------------------------
    logic addr_hit, data_hit, pc_hit;
    logic [2:0] hits;
    logic first_true, second_true;
    cdbt_trig_state_type trig_state, next_trig_state;
    logic next_halt_request, next_debug_irq_request, fire;

    always_comb begin
        addr_hit = core_obs.addr_valid
            && (((core_obs.addr ^ bkpt[IDX_ADDR]) & ~bkpt[IDX_ADDR_MASK]) == '0); // RULE_09
        data_hit = core_obs.data_valid
            && (((core_obs.data ^ bkpt[IDX_DATA]) & ~bkpt[IDX_DATA_MASK]) == '0); // RULE_09
        pc_hit = 1'b0;
        for (int i = 0; i < NUM_PC; i++) begin
            if (((core_obs.pc ^ bkpt[int'(IDX_PC_FIRST) + i]) & ~bkpt[IDX_PC_MASK]) == '0) begin
                pc_hit = core_obs.pc_valid; // RULE_09
            end
        end
        hits = {addr_hit, data_hit, pc_hit};
        // every selected comparator must hit; an empty selection never fires
        first_true = (trig_cfg.first_sel != 3'h0)
            && ((hits & trig_cfg.first_sel) == trig_cfg.first_sel); // RULE_05
        second_true = (trig_cfg.second_sel != 3'h0)
            && ((hits & trig_cfg.second_sel) == trig_cfg.second_sel); // RULE_05
    end

    always_comb begin
        next_trig_state = trig_state;
        fire = 1'b0;
        case (trig_state)
            TRG_IDLE: begin
                if (trig_cfg.enable && first_true) begin
                    if (trig_cfg.two_level) begin
                        next_trig_state = TRG_ARMED; // RULE_05
                    end else begin
                        fire = 1'b1; // RULE_05
                    end
                end
            end
            TRG_ARMED: begin
                if (!trig_cfg.enable) begin
                    next_trig_state = TRG_IDLE;
                end else if (second_true) begin
                    fire = 1'b1; // RULE_05
                    next_trig_state = TRG_IDLE;
                end
            end
            default: next_trig_state = TRG_IDLE;
        endcase
        next_halt_request = fire && !trig_cfg.irq_action; // RULE_06
        next_debug_irq_request = fire && trig_cfg.irq_action; // RULE_06
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trig_state <= TRG_IDLE;
            halt_request <= 1'b0;
            debug_irq_request <= 1'b0;
        end else if (clk_en) begin
            trig_state <= next_trig_state;
            halt_request <= next_halt_request;
            debug_irq_request <= next_debug_irq_request;
        end
    end

    // ------------------------------------------------------------
    // interrupt pass and trace outputs
    // ------------------------------------------------------------
    logic next_irq_take, next_trace_clock, next_all_high;
    logic [3:0] next_status;

    always_comb begin
        // only critical sources may break into a debug interrupt handler
        next_irq_take = irq_pending && (!debug_irq_active || irq_critical); // RULE_07
        if (core_halted) begin
            next_status = STATUS_HALTED; // RULE_02
        end else if (core_status == STATUS_HALTED) begin
            next_status = STATUS_RUN_SUBST; // RULE_02
        end else begin
            next_status = core_status; // RULE_08
        end
        next_all_high = &next_status; // RULE_01
        // flop-driven trace clock runs at half the cpu rate; data changes on each of its edges
        next_trace_clock = ~trace_clock_out; // RULE_08
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_take <= 1'b0;
            processor_status_out <= 4'h0;
            debug_data_out <= 4'h0;
            trace_clock_out <= 1'b0;
            all_status_high <= 1'b0;
        end else if (clk_en) begin
            irq_take <= next_irq_take;
            processor_status_out <= next_status; // RULE_08
            debug_data_out <= core_trace_data; // RULE_08
            trace_clock_out <= next_trace_clock;
            all_status_high <= next_all_high;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_all_high_and: assert property (@(posedge sys_clk) disable iff (reset) // RULE_01
        all_status_high == (&processor_status_out))
        else $error("all_status_high differs from status AND");
    a_halt_shows_ones: assert property (@(posedge sys_clk) disable iff (reset) // RULE_02
        (clk_en && core_halted) |=> (processor_status_out == 4'hF))
        else $error("halted core not shown as all ones");
    a_run_not_ones: assert property (@(posedge sys_clk) disable iff (reset) // RULE_02
        (clk_en && !core_halted) |=> !all_status_high)
        else $error("all_status_high while running");
    a_cpu_write_lands: assert property (@(posedge sys_clk) disable iff (reset) // RULE_04
        (clk_en && cpu_ok && cpu_write && cpu_index == 4'h0)
        |=> (bkpt[0] == $past(cpu_wdata)))
        else $error("supervisor write not stored");
    a_user_read_zero: assert property (@(posedge sys_clk) disable iff (reset) // RULE_04
        (clk_en && cpu_access && !cpu_supervisor) |=> (cpu_ack && cpu_rdata == 32'h0))
        else $error("user mode read leaked data");
    a_single_fire: assert property (@(posedge sys_clk) disable iff (reset) // RULE_05
        (clk_en && trig_state == TRG_IDLE && trig_cfg.enable && !trig_cfg.two_level
        && first_true) |=> (halt_request || debug_irq_request))
        else $error("single level trigger missed");
    a_armed_first: assert property (@(posedge sys_clk) disable iff (reset) // RULE_05
        (clk_en && trig_state == TRG_IDLE && trig_cfg.two_level)
        |=> !(halt_request || debug_irq_request))
        else $error("two level trigger fired without arming");
    a_action_split: assert property (@(posedge sys_clk) disable iff (reset) // RULE_06
        !(halt_request && debug_irq_request))
        else $error("both trigger actions at once");
    a_critical_pass: assert property (@(posedge sys_clk) disable iff (reset) // RULE_07
        (clk_en && irq_pending && irq_critical) |=> irq_take)
        else $error("critical interrupt blocked");
    a_trace_clock_runs: assert property (@(posedge sys_clk) disable iff (reset) // RULE_08
        (clk_en && !reset) |=> (trace_clock_out != $past(trace_clock_out)))
        else $error("trace clock stalled");
    a_mask_ignores: assert property (@(posedge sys_clk) disable iff (reset) // RULE_09
        (core_obs.addr_valid && bkpt[IDX_ADDR_MASK] == 32'hFFFF_FFFF) |-> addr_hit)
        else $error("fully masked address did not match");
endmodule : cdbt_debug
